// ===== verilog/stb_channel.sv
// transparent serial channel: registers, descriptor rings and byte movers
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "stb_map.svh"
module stb_channel #(
    parameter logic [7:0] FETCH_WAIT = `STB_FETCH_WAIT
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // serial receive bytes
    input wire logic rxValid,
    input wire logic [7:0] rxData,
    input wire logic rxEnd,
    input wire logic rxOverrun,
    // serial transmit bytes
    output logic txValid,
    output logic [7:0] txData,
    output logic txLast,
    input wire logic txAccept,
    // modem lines
    input wire logic cdN,
    input wire logic ctsN,
    input wire logic layer1Grant,
    // receive buffer write port
    output logic rxMemWe,
    output logic [31:0] rxMemAddr,
    output logic [7:0] rxMemData,
    output logic rxMemExt,
    output logic [2:0] rxMemFc,
    // transmit buffer read port
    output logic txMemRe,
    output logic [31:0] txMemAddr,
    output logic txMemExt,
    output logic [2:0] txMemFc,
    input wire logic txMemRvalid,
    input wire logic [7:0] txMemRdata,
    // interrupt request
    output logic irqReq
);
    function automatic logic [5:0] bdAt(input logic isTx, input logic [2:0] n,
                                        input logic [1:0] w);
        return {isTx, n, w};
    endfunction

    function automatic logic [31:0] bufAddr(input logic [31:0] ptr, input logic [15:0] cnt);
        return ptr + {16'h0, cnt};
    endfunction

    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [15:0] modeReg_ff;
    logic [7:0] eventFlags_ff;
    logic [7:0] eventMask_ff;
    logic cdLine_ff;
    logic ctsLine_ff;
    logic irqReq_ff;
    logic [15:0] paramRam [`STB_PARAM_WORDS];
    logic [15:0] bdMem [`STB_BD_WORDS];

    // apb decode
    wire logic [13:0] wordIdx = paddr[15:2];
    wire logic hitMode = wordIdx == `STB_IDX_MODE;
    wire logic hitEvent = wordIdx == `STB_IDX_EVENT;
    wire logic hitMask = wordIdx == `STB_IDX_MASK;
    wire logic hitStatus = wordIdx == `STB_IDX_STATUS;
    wire logic hitParam = wordIdx[13:5] == `STB_PARAM_BASE;
    wire logic hitBd = wordIdx[13:6] == `STB_BD_BASE;
    wire logic hitAny = hitMode | hitEvent | hitMask | hitStatus | hitParam | hitBd;
    wire logic apbFirst = psel & penable & ~pready_ff;
    wire logic apbWr = psel & penable & pready_ff & pwrite;
    wire logic [31:0] rdMux =
        hitMode ? {16'h0, modeReg_ff} :
        hitEvent ? {24'h0, eventFlags_ff} :
        hitMask ? {24'h0, eventMask_ff} :
        hitStatus ? {30'h0, cdLine_ff, ctsLine_ff} :
        hitParam ? {16'h0, paramRam[wordIdx[4:0]]} :
        hitBd ? {16'h0, bdMem[wordIdx[5:0]]} : 32'h0;

    // configuration
    wire logic rxEnabled = modeReg_ff[`STB_MODE_RXEN];
    wire logic txEnabled = modeReg_ff[`STB_MODE_TXEN];
    wire logic nonMux = modeReg_ff[`STB_MODE_NONMUX];
    wire logic [15:0] fcWord = paramRam[`STB_PRM_FC];
    wire logic [15:0] maxLen = paramRam[`STB_PRM_MAXLEN];

    // receive engine signals
    stb_pkg::stb_rx_e rxState_ff;
    stb_pkg::stb_rx_e nxt_rxState;
    logic [2:0] rxIdx_ff;
    logic [15:0] rxCnt_ff;
    logic ovPend_ff;
    logic cdPend_ff;
    logic rxMemWe_ff;
    logic [31:0] rxMemAddr_ff;
    logic [7:0] rxMemData_ff;
    logic rxMemExt_ff;
    logic [2:0] rxMemFc_ff;
    wire logic [15:0] rxCtl = bdMem[bdAt(1'b0, rxIdx_ff, 2'd0)];
    wire logic [31:0] rxPtr = {bdMem[bdAt(1'b0, rxIdx_ff, 2'd2)],
                               bdMem[bdAt(1'b0, rxIdx_ff, 2'd3)]};
    wire logic rxTake = rxValid & rxEnabled & (rxState_ff != stb_pkg::RX_DROP);
    wire logic rxEmpty = rxCtl[`STB_BD_READY];
    wire logic rxStore = rxTake & rxEmpty;
    wire logic busyEv = rxTake & ~rxEmpty;
    wire logic [15:0] rxNewCnt = rxCnt_ff + 16'h1;
    wire logic rxClose = rxStore & (rxEnd | (rxNewCnt >= maxLen));
    wire logic cdRise = cdN & ~cdLine_ff;
    wire logic ovNow = ovPend_ff | rxOverrun;
    wire logic cdLossNow = cdPend_ff | (nonMux & cdRise & (rxState_ff == stb_pkg::RX_FRAME));
    wire logic [15:0] rxCloseCtl = {1'b0, rxCtl[14:2], ovNow, cdLossNow};
    wire logic rxEv = rxClose & rxCtl[`STB_BD_INT];

    // transmit engine signals
    stb_pkg::stb_tx_e txState_ff;
    stb_pkg::stb_tx_e nxt_txState;
    logic [2:0] txIdx_ff;
    logic [15:0] txCnt_ff;
    logic [7:0] waitCnt_ff;
    logic txValid_ff;
    logic [7:0] txData_ff;
    logic txLast_ff;
    logic txMemRe_ff;
    logic [31:0] txMemAddr_ff;
    logic txMemExt_ff;
    logic [2:0] txMemFc_ff;
    wire logic [15:0] txCtl = bdMem[bdAt(1'b1, txIdx_ff, 2'd0)];
    wire logic [15:0] txLen = bdMem[bdAt(1'b1, txIdx_ff, 2'd1)];
    wire logic [31:0] txPtr = {bdMem[bdAt(1'b1, txIdx_ff, 2'd2)],
                               bdMem[bdAt(1'b1, txIdx_ff, 2'd3)]};
    wire logic txLost = nonMux ? ctsN : ~layer1Grant;
    wire logic txStart = (txState_ff == stb_pkg::TX_IDLE) & txEnabled
                       & txCtl[`STB_BD_READY];
    wire logic [15:0] txCntNext = txCnt_ff + 16'h1;
    wire logic txErrUn = (txState_ff == stb_pkg::TX_WAIT) & ~txMemRvalid
                       & (waitCnt_ff == FETCH_WAIT - 8'd1);
    wire logic txErrCt = (txState_ff != stb_pkg::TX_IDLE) & txLost;
    wire logic txErr = txErrUn | txErrCt;
    wire logic txDone = ((txState_ff == stb_pkg::TX_OUT) & txAccept & (txCntNext == txLen))
                      | (txStart & (txLen == 16'h0));
    wire logic txClose = txDone | txErr;
    wire logic [15:0] txCloseCtl = {1'b0, txCtl[14:2], txErrUn, txErrCt};
    wire logic txEv = txClose & txCtl[`STB_BD_INT] & ~txErr;
    wire logic txErrEv = txClose & txCtl[`STB_BD_INT] & txErr;

    // event flags: set wins over a one written in the same cycle
    wire logic [7:0] evSet = {ctsN ^ ctsLine_ff, cdN ^ cdLine_ff, 1'b0, txErrEv,
                              1'b0, busyEv, txEv, rxEv};
    wire logic [7:0] evClr = (apbWr & hitEvent) ? pwdata[7:0] : 8'h0;
    wire logic [7:0] nxt_eventFlags = ((eventFlags_ff & ~evClr) | evSet) & `STB_EV_IMPL;

    // apb answer one cycle into the access phase
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            prdata_ff <= 32'h0;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff <= apbFirst;
            if (apbFirst) begin
                prdata_ff <= rdMux;
                pslverr_ff <= ~hitAny;
            end
        end
    end

    // control registers and modem line samples
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            modeReg_ff <= 16'h0;
            eventFlags_ff <= 8'h0;
            eventMask_ff <= 8'h0;
            cdLine_ff <= 1'b1;
            ctsLine_ff <= 1'b1;
            irqReq_ff <= 1'b0;
        end else begin
            if (apbWr && hitMode) modeReg_ff <= pwdata[15:0] & `STB_MODE_WMASK;
            if (apbWr && hitMask) eventMask_ff <= pwdata[7:0] & `STB_MASK_IMPL;
            eventFlags_ff <= nxt_eventFlags;
            cdLine_ff <= cdN;
            ctsLine_ff <= ctsN;
            irqReq_ff <= |(eventFlags_ff & eventMask_ff);
        end
    end

    // parameter words and descriptor rings
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < `STB_PARAM_WORDS; i++) paramRam[i] <= 16'h0;
            for (int i = 0; i < `STB_BD_WORDS; i++) bdMem[i] <= 16'h0;
        end else begin
            if (apbWr && hitParam) paramRam[wordIdx[4:0]] <= pwdata[15:0];
            if (apbWr && hitBd) bdMem[wordIdx[5:0]] <= pwdata[15:0];
            if (rxClose) begin
                bdMem[bdAt(1'b0, rxIdx_ff, 2'd0)] <= rxCloseCtl;
                bdMem[bdAt(1'b0, rxIdx_ff, 2'd1)] <= rxNewCnt;
            end
            if (txClose) bdMem[bdAt(1'b1, txIdx_ff, 2'd0)] <= txCloseCtl;
        end
    end

    // receive frame tracking
    always_comb begin
        nxt_rxState = rxState_ff;
        if (!rxEnabled) begin
            nxt_rxState = stb_pkg::RX_IDLE;
        end else if (rxValid && rxEnd) begin
            nxt_rxState = stb_pkg::RX_IDLE;
        end else if (busyEv) begin
            nxt_rxState = stb_pkg::RX_DROP;
        end else if (rxStore) begin
            nxt_rxState = stb_pkg::RX_FRAME;
        end
    end
    wire logic rxFlush = rxClose | (rxValid & rxEnd) | ~rxEnabled;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rxState_ff <= stb_pkg::RX_IDLE;
            rxIdx_ff <= 3'd0;
            rxCnt_ff <= 16'h0;
            ovPend_ff <= 1'b0;
            cdPend_ff <= 1'b0;
        end else begin
            rxState_ff <= nxt_rxState;
            if (rxClose) rxIdx_ff <= rxCtl[`STB_BD_WRAP] ? 3'd0 : rxIdx_ff + 3'd1;
            if (rxFlush) begin
                rxCnt_ff <= 16'h0;
            end else if (rxStore) begin
                rxCnt_ff <= rxNewCnt;
            end
            ovPend_ff <= rxFlush ? 1'b0 : ovNow & (rxStore | (rxState_ff == stb_pkg::RX_FRAME));
            cdPend_ff <= rxFlush ? 1'b0 : cdLossNow;
        end
    end

    // receive buffer write port
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rxMemWe_ff <= 1'b0;
            rxMemAddr_ff <= 32'h0;
            rxMemData_ff <= 8'h0;
            rxMemExt_ff <= 1'b0;
            rxMemFc_ff <= 3'd0;
        end else begin
            rxMemWe_ff <= rxStore;
            if (rxStore) begin
                rxMemAddr_ff <= bufAddr(rxPtr, rxCnt_ff);
                rxMemData_ff <= rxData;
                rxMemExt_ff <= rxCtl[`STB_BD_EXT];
                rxMemFc_ff <= fcWord[14:12];
            end
        end
    end

    // transmit sequencing
    always_comb begin
        nxt_txState = txState_ff;
        unique case (txState_ff)
            stb_pkg::TX_IDLE: if (txStart) nxt_txState = stb_pkg::TX_READ;
            stb_pkg::TX_READ: nxt_txState = stb_pkg::TX_WAIT;
            stb_pkg::TX_WAIT: if (txMemRvalid) nxt_txState = stb_pkg::TX_OUT;
            stb_pkg::TX_OUT: if (txAccept) nxt_txState = stb_pkg::TX_READ;
        endcase
        if (txClose) nxt_txState = stb_pkg::TX_IDLE;
    end
    wire logic txLoad = (txState_ff == stb_pkg::TX_WAIT) & txMemRvalid & ~txClose;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            txState_ff <= stb_pkg::TX_IDLE;
            txIdx_ff <= 3'd0;
            txCnt_ff <= 16'h0;
            waitCnt_ff <= 8'h0;
            txValid_ff <= 1'b0;
            txData_ff <= 8'h0;
            txLast_ff <= 1'b0;
        end else begin
            txState_ff <= nxt_txState;
            if (txClose) txIdx_ff <= txCtl[`STB_BD_WRAP] ? 3'd0 : txIdx_ff + 3'd1;
            if (txStart) begin
                txCnt_ff <= 16'h0;
            end else if (txState_ff == stb_pkg::TX_OUT && txAccept) begin
                txCnt_ff <= txCntNext;
            end
            waitCnt_ff <= (txState_ff == stb_pkg::TX_WAIT) ? waitCnt_ff + 8'd1 : 8'h0;
            if (txLoad) begin
                txValid_ff <= 1'b1;
                txData_ff <= txMemRdata;
                txLast_ff <= txCtl[`STB_BD_LAST] & (txCntNext == txLen);
            end else if (txAccept || txClose) begin
                txValid_ff <= 1'b0;
                txLast_ff <= 1'b0;
            end
        end
    end

    // transmit buffer read port
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            txMemRe_ff <= 1'b0;
            txMemAddr_ff <= 32'h0;
            txMemExt_ff <= 1'b0;
            txMemFc_ff <= 3'd0;
        end else begin
            txMemRe_ff <= (txState_ff == stb_pkg::TX_READ) & ~txClose;
            if (txState_ff == stb_pkg::TX_READ) begin
                txMemAddr_ff <= bufAddr(txPtr, txCnt_ff);
                txMemExt_ff <= txCtl[`STB_BD_EXT];
                txMemFc_ff <= fcWord[6:4];
            end
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign txValid = txValid_ff;
    assign txData = txData_ff;
    assign txLast = txLast_ff;
    assign rxMemWe = rxMemWe_ff;
    assign rxMemAddr = rxMemAddr_ff;
    assign rxMemData = rxMemData_ff;
    assign rxMemExt = rxMemExt_ff;
    assign rxMemFc = rxMemFc_ff;
    assign txMemRe = txMemRe_ff;
    assign txMemAddr = txMemAddr_ff;
    assign txMemExt = txMemExt_ff;
    assign txMemFc = txMemFc_ff;
    assign irqReq = irqReq_ff;

    property p_busy;
        @(posedge sys_clk) disable iff (!arst_n)
        busyEv |=> eventFlags_ff[`STB_EV_DROP] && !rxMemWe_ff;
    endproperty
    a_busy: assert property (p_busy) else $error("dropped frame not flagged");
    property p_txev;
        @(posedge sys_clk) disable iff (!arst_n)
        (txClose && txCtl[`STB_BD_INT] && !txErr) |=> eventFlags_ff[`STB_EV_TX];
    endproperty
    a_txev: assert property (p_txev) else $error("transmit event missing");
    property p_txerr;
        @(posedge sys_clk) disable iff (!arst_n)
        (txErr && txCtl[`STB_BD_INT]) |=> eventFlags_ff[`STB_EV_TXERR];
    endproperty
    a_txerr: assert property (p_txerr) else $error("transmit error event missing");
    property p_rxev;
        @(posedge sys_clk) disable iff (!arst_n)
        (rxClose && rxCtl[`STB_BD_INT]) |=> eventFlags_ff[`STB_EV_RX];
    endproperty
    a_rxev: assert property (p_rxev) else $error("receive event missing");
    property p_irq;
        @(posedge sys_clk) disable iff (!arst_n)
        ##1 irqReq_ff == $past(|(eventFlags_ff & eventMask_ff));
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt request wrong");
    property p_lines;
        @(posedge sys_clk) disable iff (!arst_n)
        ##1 (cdLine_ff == $past(cdN)) && (ctsLine_ff == $past(ctsN));
    endproperty
    a_lines: assert property (p_lines) else $error("line status stale");
    property p_w1c;
        @(posedge sys_clk) disable iff (!arst_n)
        (apbWr && hitEvent && !evSet[`STB_EV_RX]) |=>
            eventFlags_ff[`STB_EV_RX] == ($past(eventFlags_ff[`STB_EV_RX])
                                          && !$past(pwdata[`STB_EV_RX]));
    endproperty
    a_w1c: assert property (p_w1c) else $error("event clear misbehaved");
    property p_wrap;
        @(posedge sys_clk) disable iff (!arst_n)
        (rxClose && rxCtl[`STB_BD_WRAP]) |=> rxIdx_ff == 3'd0;
    endproperty
    a_wrap: assert property (p_wrap) else $error("receive ring did not wrap");
    property p_rxlen;
        @(posedge sys_clk) disable iff (!arst_n)
        rxClose |=> bdMem[bdAt(1'b0, $past(rxIdx_ff), 2'd1)] == $past(rxNewCnt)
                    && !bdMem[bdAt(1'b0, $past(rxIdx_ff), 2'd0)][`STB_BD_READY];
    endproperty
    a_rxlen: assert property (p_rxlen) else $error("receive close word wrong");
    property p_txready;
        @(posedge sys_clk) disable iff (!arst_n)
        (txState_ff == stb_pkg::TX_READ && $past(txState_ff) == stb_pkg::TX_IDLE)
            |-> $past(txCtl[`STB_BD_READY]) && $past(txEnabled);
    endproperty
    a_txready: assert property (p_txready) else $error("sent from unready buffer");
endmodule
`default_nettype wire

// ===== verilog/stb_map.svh
// register map, field positions and timing counts of the transparent channel
// Operation
// - drop frame without empty buffer, flag busy
// - transmit event only when descriptor interrupt set
// - receive event only when descriptor interrupt set
// - eight-bit mask mirrors event bits, one enables; mask also keeps bit 3, which has no event bit
// - status bit 1 shows carrier detect level
// - status bit 0 shows clear-to-send level
// - thirty-two parameter words, fourteen general, eighteen protocol
// - sixteen-bit maximum receive buffer length
// - receive close clears empty, reports error bits
// - receive only into descriptors marked empty
// - external flag picks internal or external memory
// - wrap flag returns ring to first descriptor
// - receive close with interrupt flag raises event
// - flag overrun and, in non-multiplexed mode only, mid-frame carrier loss
// - receive length word holds stored byte count
// - transmit close clears ready, reports error bits
// - transmit only from descriptors marked ready
// - transmit close with interrupt flag raises buffer or error event
// - last flag ends the transmitted block
// - flag underrun and lost clear-to-send or grant
// - event flags clear only by writing ones
// - enable bits gate reception and transmission
`ifndef STB_MAP_SVH
`define STB_MAP_SVH
`define STB_IDX_MODE 14'h0884
`define STB_IDX_EVENT 14'h0888
`define STB_IDX_MASK 14'h088a
`define STB_IDX_STATUS 14'h088c
`define STB_PARAM_BASE 9'h048
`define STB_BD_BASE 8'h28
`define STB_PARAM_WORDS 32
`define STB_BD_WORDS 64
`define STB_PRM_FC 5'd0
`define STB_PRM_MAXLEN 5'd1
`define STB_MODE_TXEN 2
`define STB_MODE_RXEN 3
`define STB_MODE_NONMUX 8
`define STB_MODE_WMASK 16'h010c
`define STB_EV_RX 0
`define STB_EV_TX 1
`define STB_EV_DROP 2
`define STB_EV_TXERR 4
`define STB_EV_CD 6
`define STB_EV_CTS 7
`define STB_EV_IMPL 8'hd7
`define STB_MASK_IMPL 8'hdf
`define STB_BD_READY 15
`define STB_BD_EXT 14
`define STB_BD_WRAP 13
`define STB_BD_INT 12
`define STB_BD_LAST 11
`define STB_BD_OVR 1
`define STB_BD_CDL 0
`define STB_BD_UNDR 1
`define STB_BD_CTSL 0
`define STB_FETCH_WAIT 8'd8
`endif

// ===== verilog/stb_pkg.sv
// state types of the transparent channel
package stb_pkg;
    typedef enum logic [1:0] {RX_IDLE, RX_FRAME, RX_DROP} stb_rx_e;
    typedef enum logic [1:0] {TX_IDLE, TX_READ, TX_WAIT, TX_OUT} stb_tx_e;
endpackage

// ===== tb/stb_line_model.sv
// serial line and buffer memory partner of the transparent channel
`timescale 1ns/1ps
`default_nettype none
module stb_line_model (
    // clock
    input wire logic sys_clk,
    // receive side
    output logic rxValid,
    output logic [7:0] rxData,
    output logic rxEnd,
    output logic rxOverrun,
    input wire logic rxMemWe,
    input wire logic [31:0] rxMemAddr,
    input wire logic [2:0] rxMemFc,
    input wire logic [7:0] rxMemData,
    input wire logic rxMemExt,
    // transmit side
    input wire logic txValid,
    input wire logic [7:0] txData,
    input wire logic txLast,
    output logic txAccept,
    input wire logic txMemRe,
    input wire logic [31:0] txMemAddr,
    input wire logic txMemExt,
    input wire logic [2:0] txMemFc,
    output logic txMemRvalid,
    output logic [7:0] txMemRdata,
    // modem lines
    output logic cdN,
    output logic ctsN,
    output logic layer1Grant
);
    logic memSilent;
    logic lastSeen;
    logic extSeen;
    logic [15:0] txBytes;
    logic [31:0] lastRxAddr;
    logic [2:0] lastRxFc;
    logic [7:0] lastRxData;
    logic lastRxExt;
    logic [2:0] txFcSeen;
    int acceptDelay = 3;
    int waitCnt = 0;
    int txCount = 0;
    int rxWrites = 0;
    initial begin
        {rxValid, rxEnd, rxOverrun, txAccept, txMemRvalid, memSilent} = 6'h00;
        {lastSeen, extSeen, txBytes, lastRxAddr, lastRxFc, lastRxData, lastRxExt, txFcSeen} = '0;
        {cdN, ctsN, layer1Grant} = 3'h7;
        rxData = 8'h00;
        txMemRdata = 8'h00;
    end
    // buffer memory answers one cycle later with the address low byte
    always @(posedge sys_clk) begin
        txMemRvalid <= txMemRe && !memSilent;
        txMemRdata <= (txMemRe && !memSilent) ? txMemAddr[7:0] : ~txMemRdata;
        if (txMemRe) begin
            extSeen <= txMemExt;
            txFcSeen <= txMemFc;
        end
        if (rxMemWe) begin
            rxWrites <= rxWrites + 1;
            lastRxAddr <= rxMemAddr;
            lastRxFc <= rxMemFc;
            lastRxData <= rxMemData;
            lastRxExt <= rxMemExt;
        end
        // slow line: takes a byte after a few cycles
        txAccept <= txValid && !txAccept && waitCnt >= acceptDelay;
        if (txAccept) waitCnt <= 0;
        else if (txValid && waitCnt < acceptDelay) waitCnt <= waitCnt + 1;
        if (txValid && txAccept) begin
            txCount <= txCount + 1;
            txBytes <= {txBytes[7:0], txData};
            lastSeen <= txLast;
        end
    end
    task automatic send_frame(input int n, input logic ovr);
        for (int i = 0; i < n; i++) begin
            @(posedge sys_clk);
            rxValid <= 1'b1;
            rxData <= 8'h10 + 8'(i);
            rxEnd <= (i == n - 1);
            rxOverrun <= ovr && (i == 0);
        end
        @(posedge sys_clk);
        rxValid <= 1'b0;
        rxEnd <= 1'b0;
        rxOverrun <= 1'b0;
        rxData <= ~rxData;
    endtask
endmodule
`default_nettype wire

// ===== tb/tb_serial_transparent_bd_events.sv
// self-checking bench of the transparent channel
`timescale 1ns/1ps
`default_nettype none
module tb_serial_transparent_bd_events;
    localparam logic [15:0] A_MODE = 16'h2210, A_EV = 16'h2220, A_MASK = 16'h2228;
    localparam logic [15:0] A_ST = 16'h2230, A_RX = 16'h2800, A_TX = 16'h2880;
    logic sys_clk, arst_n, psel, penable, pwrite, pready, pslverr, e;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic rxValid, rxEnd, rxOverrun, txValid, txLast, txAccept, cdN, ctsN, layer1Grant;
    logic [7:0] rxData, txData, txMemRdata, rxMemData;
    logic rxMemWe, txMemRe, txMemExt, txMemRvalid, irqReq, rxMemExt;
    logic [31:0] rxMemAddr, txMemAddr;
    logic [2:0] rxMemFc, txMemFc;
    int error_cnt = 0;
    int compares = 0;
    int n;
    always #5 sys_clk = ~sys_clk;
    stb_channel #(.FETCH_WAIT(8'd2)) u_dut (.sys_clk(sys_clk), .arst_n(arst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxValid(rxValid),
        .rxData(rxData), .rxEnd(rxEnd), .rxOverrun(rxOverrun), .txValid(txValid),
        .txData(txData), .txLast(txLast), .txAccept(txAccept), .cdN(cdN), .ctsN(ctsN),
        .layer1Grant(layer1Grant), .rxMemWe(rxMemWe), .rxMemAddr(rxMemAddr),
        .rxMemData(rxMemData), .rxMemExt(rxMemExt), .rxMemFc(rxMemFc), .txMemRe(txMemRe),
        .txMemAddr(txMemAddr), .txMemExt(txMemExt), .txMemFc(txMemFc),
        .txMemRvalid(txMemRvalid), .txMemRdata(txMemRdata), .irqReq(irqReq));
    stb_line_model u_line (.sys_clk(sys_clk), .rxValid(rxValid), .rxData(rxData),
        .rxEnd(rxEnd), .rxOverrun(rxOverrun), .rxMemWe(rxMemWe), .rxMemAddr(rxMemAddr),
        .rxMemFc(rxMemFc), .rxMemData(rxMemData), .rxMemExt(rxMemExt), .txValid(txValid),
        .txData(txData), .txLast(txLast), .txAccept(txAccept), .txMemRe(txMemRe),
        .txMemAddr(txMemAddr), .txMemExt(txMemExt), .txMemFc(txMemFc),
        .txMemRvalid(txMemRvalid), .txMemRdata(txMemRdata),
        .cdN(cdN), .ctsN(ctsN), .layer1Grant(layer1Grant));
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] x);
        compares++;
        if (seen !== x) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, x, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) error_cnt++;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input string nm, input logic [15:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        check(nm, q, x);
    endtask
    task automatic cyc(input int c);
        repeat (c) @(posedge sys_clk);
    endtask
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        #300000;
        error_cnt++;
        give_verdict();
    end
    initial begin
        {sys_clk, arst_n, psel, penable, pwrite} = 5'h0;
        paddr = 16'h0000;
        pwdata = 32'h0;
        cyc(8);
        arst_n <= 1'b1;
        rdc("mask", A_MASK, 32'h0);
        rdc("status", A_ST, 32'h3);
        apb(1'b0, 16'h0000, 32'h0);
        check("slverr", {31'h0, e}, 32'h1);
        check("unmapped", q, 32'h0);
        u_line.cdN <= 1'b0;
        u_line.ctsN <= 1'b0;
        cyc(3);
        rdc("status", A_ST, 32'h0);
        wr(A_EV, 32'h0);
        rdc("events", A_EV, 32'hc0);
        wr(A_EV, 32'hff);
        rdc("events", A_EV, 32'h0);
        wr(A_MASK, 32'hff);
        rdc("mask", A_MASK, 32'hdf);
        wr(A_MASK, 32'h17);
        wr(16'h2400, 32'h5050);
        rdc("fc", 16'h2400, 32'h5050);
        wr(16'h2404, 32'h4);
        rdc("maxlen", 16'h2404, 32'h4);
        wr(16'h247c, 32'hbeef);
        rdc("word31", 16'h247c, 32'hbeef);
        $display("test registers done");
        wr(A_RX, 32'h9000);
        wr(A_RX + 12, 32'h0100);
        wr(A_RX + 16, 32'ha000);
        wr(A_RX + 28, 32'h0200);
        wr(A_MODE, 32'h8);
        u_line.send_frame(3, 1'b0);
        cyc(4);
        rdc("rx0 ctl", A_RX, 32'h1000);
        rdc("rx0 len", A_RX + 4, 32'h3);
        rdc("events", A_EV, 32'h1);
        check("irq", {31'h0, irqReq}, 32'h1);
        check("rx addr", u_line.lastRxAddr, 32'h102);
        check("rx fc", {29'h0, u_line.lastRxFc}, 32'h5);
        check("rx data", {24'h0, u_line.lastRxData}, 32'h12);
        check("rx ext", {31'h0, u_line.lastRxExt}, 32'h0);
        wr(A_EV, 32'h1);
        cyc(2);
        check("irq", {31'h0, irqReq}, 32'h0);
        u_line.send_frame(2, 1'b1);
        cyc(4);
        rdc("rx1 ctl", A_RX + 16, 32'h2002);
        rdc("rx1 len", A_RX + 20, 32'h2);
        rdc("events", A_EV, 32'h0);
        wr(A_RX, 32'h9000);
        u_line.send_frame(2, 1'b0);
        cyc(4);
        check("wrap addr", u_line.lastRxAddr, 32'h101);
        rdc("events", A_EV, 32'h1);
        wr(A_EV, 32'hff);
        n = u_line.rxWrites;
        u_line.send_frame(2, 1'b0);
        cyc(4);
        rdc("events", A_EV, 32'h4);
        check("rx writes", u_line.rxWrites, n);
        wr(A_EV, 32'hff);
        wr(A_RX + 16, 32'ha000);
        wr(A_MODE, 32'h108);
        fork
            u_line.send_frame(3, 1'b0);
            begin
                cyc(2);
                u_line.cdN <= 1'b1;
            end
        join
        cyc(4);
        rdc("rx1 ctl", A_RX + 16, 32'h2001);
        rdc("events", A_EV, 32'h40);
        wr(A_EV, 32'hff);
        $display("test receive done");
        wr(A_TX + 4, 32'h2);
        wr(A_TX + 12, 32'h0300);
        wr(A_TX, 32'hf800);
        cyc(20);
        check("tx idle", u_line.txCount, 32'h0);
        wr(A_MODE, 32'hc);
        for (int i = 0; i < 300 && u_line.txCount < 2; i++) cyc(1);
        cyc(5);
        check("tx bytes", {16'h0, u_line.txBytes}, 32'h0001);
        check("tx last", {31'h0, u_line.lastSeen}, 32'h1);
        check("tx ext", {31'h0, u_line.extSeen}, 32'h1);
        check("tx fc", {29'h0, u_line.txFcSeen}, 32'h5);
        rdc("tx ctl", A_TX, 32'h7800);
        rdc("events", A_EV, 32'h2);
        wr(A_EV, 32'hff);
        u_line.memSilent <= 1'b1;
        wr(A_TX + 4, 32'h1);
        wr(A_TX, 32'hb000);
        cyc(30);
        rdc("tx ctl", A_TX, 32'h3002);
        rdc("events", A_EV, 32'h10);
        wr(A_EV, 32'hff);
        u_line.ctsN <= 1'b1;
        wr(A_MODE, 32'h10c);
        wr(A_TX, 32'hb000);
        cyc(10);
        rdc("tx ctl", A_TX, 32'h3001);
        rdc("events", A_EV, 32'h90);
        $display("test transmit done");
        give_verdict();
    end
endmodule
`default_nettype wire
